// >>> rtl/pcib_defines.svh
// Constants of the shared bus signalling block: commands, windows, counts.
// Assumes inclusion by both bus ends; definitions only.
`ifndef PCIB_DEFINES_SVH
`define PCIB_DEFINES_SVH
// ==========================================================
// Bus commands as carried on the low command lines
`define PCIB_CMD_IO_RD 4'h2
`define PCIB_CMD_IO_WR 4'h3
`define PCIB_CMD_MEM_RD 4'h6
`define PCIB_CMD_MEM_WR 4'h7
`define PCIB_CMD_CFG_RD 4'ha
`define PCIB_CMD_CFG_WR 4'hb
// ==========================================================
// Address windows claimed by each end
`define PCIB_DEV_MEM_BASE 64'h0000_0000_8000_0000
`define PCIB_DEV_IO_BASE 32'h0000_1000
`define PCIB_HOST_MEM_BASE 64'h0000_0000_0010_0000
// ==========================================================
// Clocks a master waits for a claim before giving up
`define PCIB_DEVSEL_WAIT 3'h5
// Last word index of the device target store
`define PCIB_LAST_IDX 2'h3
`endif

// >>> rtl/pcib_pkg.sv
// Types and drive helpers shared by both bus ends and the carrier.
// Assumes one common bus clock; no tool-specific features.
package pcib_pkg;
	// ==========================================================
	// Values one agent puts on the bus (active-low fields end _n)
	typedef struct packed {
		logic [63:0] ad;
		logic [7:0] cbe_n;
		logic par;
		logic par64;
		logic frame_n;
		logic irdy_n;
		logic trdy_n;
		logic stop_n;
		logic devsel_n;
	} pcib_drv_t;
	// Output enables of one agent, high while driving
	typedef struct packed {
		logic ad_lo;
		logic ad_hi;
		logic cbe_lo;
		logic cbe_hi;
		logic par;
		logic par64;
		logic frame;
		logic irdy;
		logic trdy;
		logic stop;
		logic devsel;
	} pcib_oe_t;
	typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_END} pcib_mst_st_t;
	typedef enum logic [1:0] {T_IDLE, T_DATA, T_END} pcib_tgt_st_t;
	// ==========================================================
	// Sustained line: a low line is driven high one clock before release
	function automatic logic pcib_sts_oe(logic want, logic oe_q,
		logic val_q);
		return want | (oe_q & ~val_q);
	endfunction : pcib_sts_oe
	// Next drive values; parity covers what was driven one clock earlier
	function automatic pcib_drv_t pcib_drv_next(pcib_drv_t v,
		pcib_drv_t q);
		pcib_drv_t r;
		r = v;
		r.par = ^{q.ad[31:0], q.cbe_n[3:0]};
		r.par64 = ^{q.ad[63:32], q.cbe_n[7:4]};
		return r;
	endfunction : pcib_drv_next
	// Next enables; upper lanes only join on a wide bus
	function automatic pcib_oe_t pcib_oe_next(pcib_oe_t w, pcib_oe_t q,
		pcib_drv_t d, logic wide);
		pcib_oe_t r;
		r.ad_lo = w.ad_lo;
		r.ad_hi = w.ad_lo & wide;
		r.cbe_lo = w.cbe_lo;
		r.cbe_hi = w.cbe_lo & wide;
		r.par = q.ad_lo;
		r.par64 = q.ad_hi;
		r.frame = pcib_sts_oe(w.frame, q.frame, d.frame_n);
		r.irdy = pcib_sts_oe(w.irdy, q.irdy, d.irdy_n);
		r.trdy = pcib_sts_oe(w.trdy, q.trdy, d.trdy_n);
		r.stop = pcib_sts_oe(w.stop, q.stop, d.stop_n);
		r.devsel = pcib_sts_oe(w.devsel, q.devsel, d.devsel_n);
		return r;
	endfunction : pcib_oe_next
endpackage : pcib_pkg

// >>> rtl/pcib_if.sv
// Carrier joining the device end and the host end of the shared bus.
// Resolves each line from both ends' enables; sustained lines pull high.
`timescale 1ns/1ps
interface pcib_if;
	import pcib_pkg::*;
	// ==========================================================
	// Per-end drive and enables, resolved bus, host-set straps
	pcib_drv_t dev_drv;
	pcib_oe_t dev_oe;
	pcib_drv_t host_drv;
	pcib_oe_t host_oe;
	pcib_drv_t bus;
	logic idsel; // Chip select for configuration accesses
	logic wide; // High when the upper lanes are wired up
	// Pulled-up line: low if any enabled end drives low
	function automatic logic pull(logic oa, logic va, logic ob, logic vb);
		return (~oa | va) & (~ob | vb);
	endfunction : pull
	// Plain line: reads low when nobody drives it
	function automatic logic mux(logic oa, logic va, logic ob, logic vb);
		return (oa & va) | (ob & vb);
	endfunction : mux
	// ==========================================================
	// Resolution
	for (genvar i = 0; i < 64; i++) begin : g_ad
		localparam bit HI = (i >= 32);
		assign bus.ad[i] = mux(HI ? dev_oe.ad_hi : dev_oe.ad_lo,
			dev_drv.ad[i], HI ? host_oe.ad_hi : host_oe.ad_lo,
			host_drv.ad[i]);
	end
	for (genvar i = 0; i < 8; i++) begin : g_cbe
		localparam bit HI = (i >= 4);
		assign bus.cbe_n[i] = pull(HI ? dev_oe.cbe_hi : dev_oe.cbe_lo,
			dev_drv.cbe_n[i], HI ? host_oe.cbe_hi : host_oe.cbe_lo,
			host_drv.cbe_n[i]);
	end
	assign bus.par = mux(dev_oe.par, dev_drv.par, host_oe.par,
		host_drv.par);
	assign bus.par64 = mux(dev_oe.par64, dev_drv.par64, host_oe.par64,
		host_drv.par64);
	assign bus.frame_n = pull(dev_oe.frame, dev_drv.frame_n,
		host_oe.frame, host_drv.frame_n);
	assign bus.irdy_n = pull(dev_oe.irdy, dev_drv.irdy_n,
		host_oe.irdy, host_drv.irdy_n);
	assign bus.trdy_n = pull(dev_oe.trdy, dev_drv.trdy_n,
		host_oe.trdy, host_drv.trdy_n);
	assign bus.stop_n = pull(dev_oe.stop, dev_drv.stop_n,
		host_oe.stop, host_drv.stop_n);
	assign bus.devsel_n = pull(dev_oe.devsel, dev_drv.devsel_n,
		host_oe.devsel, host_drv.devsel_n);
	modport dev(input bus, input idsel, input wide,
		output dev_drv, output dev_oe);
	modport host(input bus, output host_drv, output host_oe,
		output idsel, output wide);
endinterface : pcib_if

// >>> rtl/pcib_dev.sv
// Device end of the shared bus: burst-read/single-write master and a
// four-word target reached by memory, I/O and configuration commands.
// Assumes the far end runs on the same clock and obeys the handshakes.
`timescale 1ns/1ps
`include "pcib_defines.svh"
module pcib_dev import pcib_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Bus
	pcib_if.dev bus_if,
	// Master request
	input wire logic mst_req_i,
	input wire logic [3:0] mst_cmd_i,
	input wire logic [63:0] mst_addr_i,
	input wire logic [3:0] mst_len_i,
	input wire logic [63:0] mst_wdata_i,
	input wire logic [7:0] mst_be_i,
	// Master answer
	output logic mst_busy_o,
	output logic [63:0] mst_rdata_o,
	output logic mst_rvalid_o,
	output logic mst_done_o,
	output logic mst_abort_o,
	output logic mst_stopped_o,
	// Target user side
	input wire logic tgt_busy_i,
	output logic tgt_wr_o,
	output logic tgt_rd_o,
	output logic [63:0] tgt_addr_o,
	output logic [63:0] tgt_wdata_o,
	output logic [7:0] tgt_be_o
);
	// ==========================================================
	// Declarations
	localparam logic [63:0] MEM_BASE = `PCIB_DEV_MEM_BASE;
	localparam logic [31:0] IO_BASE = `PCIB_DEV_IO_BASE;
	pcib_drv_t bus; // Resolved lines, read at the rising edge
	pcib_drv_t drv_q; // Our drive values
	pcib_drv_t v_d;
	pcib_oe_t oe_q; // Our enables
	pcib_oe_t w_d;
	pcib_mst_st_t m_st_q, m_st_d;
	logic [3:0] m_cnt_q, m_cnt_d; // Data phases still to go
	logic [2:0] m_tmo_q, m_tmo_d; // Clocks without a claim
	logic m_wr_q;
	logic [63:0] m_data_q;
	logic [7:0] m_be_q;
	logic m_start, m_end, m_abort_d, m_stop_d;
	logic m_frame_w, m_irdy_w, m_ad_w, m_cbe_w;
	logic [63:0] m_ad_v;
	logic [7:0] m_cbe_v;
	pcib_tgt_st_t t_st_q, t_st_d;
	logic [1:0] t_idx_q, t_idx_d; // Word index in the store
	logic t_wr_q, t_stop_q, t_stop_d;
	logic [63:0] t_addr_q;
	logic [63:0] store_q [4]; // Target store, one word per index
	logic t_cap, t_wr_p, t_rd_p;
	logic devsel_w, trdy_w, stop_w, t_ad_w;
	logic frame_prev_q; // Frame line one clock earlier
	// Lane merge under active-low enables
	function automatic logic [63:0] merge(logic [63:0] old,
		logic [63:0] nw, logic [7:0] be_n);
		logic [63:0] r;
		r = old;
		for (int i = 0; i < 8; i++) begin
			if (!be_n[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : merge
	// ==========================================================
	// Decoding of the sampled bus
	assign bus = bus_if.bus;
	wire [3:0] cmd = bus.cbe_n[3:0];
	wire adph = ~bus.frame_n & frame_prev_q;
	wire both_rdy = ~bus.irdy_n & ~bus.trdy_n;
	wire m_xfer = (m_st_q == M_DATA) & both_rdy;
	wire t_xfer = (t_st_q == T_DATA) & both_rdy;
	wire hit_cfg = ((cmd == `PCIB_CMD_CFG_RD) | (cmd == `PCIB_CMD_CFG_WR))
		& bus_if.idsel & (bus.ad[1:0] == 2'h0);
	wire hit_mem = ((cmd == `PCIB_CMD_MEM_RD) | (cmd == `PCIB_CMD_MEM_WR))
		& (bus.ad[63:5] == MEM_BASE[63:5]);
	wire hit_io = ((cmd == `PCIB_CMD_IO_RD) | (cmd == `PCIB_CMD_IO_WR))
		& (bus.ad[31:5] == IO_BASE[31:5]);
	wire t_hit = adph & (m_st_q != M_ADDR) & (hit_cfg | hit_mem | hit_io);
	// Upper lanes read as zero on a narrow bus
	wire [63:0] ad_in = bus_if.wide ? bus.ad : {32'h0, bus.ad[31:0]};
	wire [7:0] be_in = bus_if.wide ? ~bus.cbe_n : {4'h0, ~bus.cbe_n[3:0]};
	wire bus_idle = bus.frame_n & bus.irdy_n;
	// ==========================================================
	// Master sequencing
	always_comb begin
		m_st_d = m_st_q;
		m_cnt_d = m_cnt_q;
		m_tmo_d = m_tmo_q;
		m_start = 1'b0;
		m_end = 1'b0;
		m_abort_d = 1'b0;
		m_stop_d = 1'b0;
		m_frame_w = 1'b0;
		m_irdy_w = 1'b0;
		m_ad_w = 1'b0;
		m_cbe_w = 1'b0;
		m_ad_v = m_data_q;
		m_cbe_v = ~m_be_q;
		case (m_st_q)
			M_IDLE: begin
				// Start only on an idle bus, never over our own target
				if (mst_req_i & bus_idle & (t_st_q == T_IDLE) & ~adph) begin
					m_start = 1'b1;
					m_st_d = M_ADDR;
					m_cnt_d = (mst_cmd_i[0] | (mst_len_i == 4'h0)) ?
						4'h1 : mst_len_i;
					m_frame_w = 1'b1;
					m_ad_w = 1'b1;
					m_cbe_w = 1'b1;
					m_ad_v = mst_addr_i;
					m_cbe_v = {mst_cmd_i, mst_cmd_i};
				end
			end
			M_ADDR: begin
				m_st_d = M_DATA;
				m_tmo_d = 3'h0;
				m_frame_w = (m_cnt_q > 4'h1);
				m_irdy_w = 1'b1;
				m_ad_w = m_wr_q;
				m_cbe_w = 1'b1;
			end
			M_DATA: begin
				m_frame_w = (m_cnt_q > 4'h1);
				m_irdy_w = 1'b1;
				m_ad_w = m_wr_q;
				m_cbe_w = 1'b1;
				if (m_xfer) begin
					m_cnt_d = m_cnt_q - 4'h1;
					m_frame_w = (m_cnt_q > 4'h2);
					if ((m_cnt_q == 4'h1) | ~bus.stop_n) begin
						m_end = 1'b1;
						m_stop_d = (m_cnt_q != 4'h1);
					end
				end else if (~bus.stop_n) begin
					// Retry or disconnect without data
					m_end = 1'b1;
					m_stop_d = 1'b1;
				end else if (bus.devsel_n) begin
					m_tmo_d = m_tmo_q + 3'h1;
					if (m_tmo_q >= `PCIB_DEVSEL_WAIT - 3'h1) begin
						m_end = 1'b1;
						m_abort_d = 1'b1;
					end
				end
				// Frame still low: drop it first, end one clock later
				if (m_end & (m_cnt_q > 4'h1)) begin
					m_end = 1'b0;
					m_abort_d = 1'b0;
					m_stop_d = 1'b0;
					m_cnt_d = 4'h1;
					m_frame_w = 1'b0;
				end
				if (m_end) begin
					m_st_d = M_END;
					m_frame_w = 1'b0;
					m_irdy_w = 1'b0;
					m_ad_w = 1'b0;
					m_cbe_w = 1'b0;
				end
			end
			M_END: begin
				// Idle clock lets released lines settle
				m_st_d = M_IDLE;
			end
			default: begin
				m_st_d = M_IDLE;
			end
		endcase
	end
	// ==========================================================
	// Target sequencing
	always_comb begin
		t_st_d = t_st_q;
		t_idx_d = t_idx_q;
		t_stop_d = t_stop_q;
		t_cap = 1'b0;
		t_wr_p = 1'b0;
		t_rd_p = 1'b0;
		devsel_w = 1'b0;
		trdy_w = 1'b0;
		stop_w = 1'b0;
		t_ad_w = 1'b0;
		case (t_st_q)
			T_IDLE: begin
				if (t_hit) begin
					t_st_d = T_DATA;
					t_cap = 1'b1;
					t_idx_d = bus.ad[4:3];
					t_stop_d = 1'b0;
					devsel_w = 1'b1;
				end
			end
			T_DATA: begin
				devsel_w = 1'b1;
				t_ad_w = ~t_wr_q;
				if (t_xfer) begin
					t_wr_p = t_wr_q;
					t_rd_p = ~t_wr_q;
					t_idx_d = t_idx_q + 2'h1;
					// Past the last word: disconnect
					if (t_idx_q == `PCIB_LAST_IDX) begin
						t_stop_d = 1'b1;
					end
				end
				if (bus.frame_n & (t_xfer | bus.irdy_n)) begin
					t_st_d = T_END;
					devsel_w = 1'b0;
					t_ad_w = 1'b0;
				end else begin
					trdy_w = ~tgt_busy_i & ~t_stop_d;
					stop_w = t_stop_d;
				end
			end
			T_END: begin
				t_st_d = T_IDLE;
			end
			default: begin
				t_st_d = T_IDLE;
			end
		endcase
	end
	// ==========================================================
	// Drive assembly; master and target never own AD together
	assign v_d.ad = m_ad_w ? m_ad_v : store_q[t_idx_d];
	assign v_d.cbe_n = m_cbe_v;
	assign v_d.par = 1'b0;
	assign v_d.par64 = 1'b0;
	assign v_d.frame_n = ~m_frame_w;
	assign v_d.irdy_n = ~m_irdy_w;
	assign v_d.trdy_n = ~trdy_w;
	assign v_d.stop_n = ~stop_w;
	assign v_d.devsel_n = ~devsel_w;
	assign w_d = '{ad_lo: m_ad_w | t_ad_w, ad_hi: 1'b0, cbe_lo: m_cbe_w,
		cbe_hi: 1'b0, par: 1'b0, par64: 1'b0, frame: m_frame_w,
		irdy: m_irdy_w, trdy: trdy_w, stop: stop_w, devsel: devsel_w};
	assign bus_if.dev_drv = drv_q;
	assign bus_if.dev_oe = oe_q;
	// ==========================================================
	// Bus output flops; reset releases every line
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			drv_q <= '1;
			oe_q <= '0;
			frame_prev_q <= 1'b1;
		end else begin
			// Parity covers the resolved lines, as the master drives CBE
			drv_q <= pcib_drv_next(v_d, bus);
			oe_q <= pcib_oe_next(w_d, oe_q, drv_q,
				bus_if.wide);
			frame_prev_q <= bus.frame_n;
		end
	end
	// State flops
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			m_st_q <= M_IDLE;
			t_st_q <= T_IDLE;
			m_cnt_q <= 4'h0;
			m_tmo_q <= 3'h0;
			t_idx_q <= 2'h0;
			t_stop_q <= 1'b0;
			// Cleared so unwritten lanes never put unknowns on the bus
			store_q <= '{default: 64'h0};
		end else begin
			m_st_q <= m_st_d;
			t_st_q <= t_st_d;
			m_cnt_q <= m_cnt_d;
			m_tmo_q <= m_tmo_d;
			t_idx_q <= t_idx_d;
			t_stop_q <= t_stop_d;
			if (t_wr_p) begin
				store_q[t_idx_q] <= merge(store_q[t_idx_q], ad_in,
					bus.cbe_n);
			end
		end
	end
	// Captured request and address fields; no reset needed
	always_ff @(posedge ref_clk_i) begin
		if (m_start) begin
			m_wr_q <= mst_cmd_i[0];
			m_data_q <= mst_wdata_i;
			m_be_q <= mst_be_i;
		end
		if (t_cap) begin
			t_wr_q <= cmd[0];
			t_addr_q <= bus.ad;
		end
	end
	// User-side answers
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			mst_busy_o <= 1'b0;
			mst_rdata_o <= 64'h0;
			mst_rvalid_o <= 1'b0;
			mst_done_o <= 1'b0;
			mst_abort_o <= 1'b0;
			mst_stopped_o <= 1'b0;
			tgt_wr_o <= 1'b0;
			tgt_rd_o <= 1'b0;
			tgt_addr_o <= 64'h0;
			tgt_wdata_o <= 64'h0;
			tgt_be_o <= 8'h0;
		end else begin
			mst_busy_o <= (m_st_d != M_IDLE);
			mst_rvalid_o <= m_xfer & ~m_wr_q;
			if (m_xfer) begin
				mst_rdata_o <= ad_in;
			end
			mst_done_o <= m_end;
			mst_abort_o <= m_abort_d;
			mst_stopped_o <= m_stop_d;
			tgt_wr_o <= t_wr_p;
			tgt_rd_o <= t_rd_p;
			if (t_xfer) begin
				tgt_addr_o <= {t_addr_q[63:5], t_idx_q, t_addr_q[2:0]};
				tgt_wdata_o <= ad_in;
				tgt_be_o <= be_in;
			end
		end
	end
endmodule : pcib_dev

// >>> rtl/pcib_host.sv
// Host end of the shared bus: single-phase initiator toward the device
// and a one-word target that answers the device's master cycles.
// Assumes the same bus clock as the device end.
`timescale 1ns/1ps
`include "pcib_defines.svh"
module pcib_host import pcib_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Bus
	pcib_if.host bus_if,
	// Straps
	input wire logic h_idsel_i,
	input wire logic h_wide_i,
	// Initiator request and answer
	input wire logic h_req_i,
	input wire logic [3:0] h_cmd_i,
	input wire logic [63:0] h_addr_i,
	input wire logic [63:0] h_wdata_i,
	input wire logic [7:0] h_be_i,
	output logic h_busy_o,
	output logic [63:0] h_rdata_o,
	output logic h_done_o,
	output logic h_abort_o,
	// Target user side
	input wire logic [63:0] h_tgt_rdata_i,
	input wire logic h_tgt_disc_i,
	output logic h_tgt_wr_o,
	output logic [63:0] h_tgt_wdata_o,
	output logic [7:0] h_tgt_be_o
);
	// ==========================================================
	// Declarations
	localparam logic [63:0] HOST_BASE = `PCIB_HOST_MEM_BASE;
	pcib_drv_t bus;
	pcib_drv_t drv_q;
	pcib_drv_t v_d;
	pcib_oe_t oe_q;
	pcib_oe_t w_d;
	pcib_mst_st_t m_st_q, m_st_d;
	pcib_tgt_st_t t_st_q, t_st_d;
	logic [2:0] tmo_q; // Clocks spent in the data phase
	logic wr_q, t_wr_q, t_stop_q, frame_prev_q, idsel_q, wide_q;
	logic [63:0] ad_q; // Write data only; the address goes out straight from h_addr_i
	logic [7:0] be_q;
	logic [3:0] cmd_q;
	assign bus = bus_if.bus;
	// ==========================================================
	// Decoding
	wire both_rdy = ~bus.irdy_n & ~bus.trdy_n;
	wire m_xfer = (m_st_q == M_DATA) & both_rdy;
	wire m_tmo = (m_st_q == M_DATA) & bus.devsel_n &
		(tmo_q == `PCIB_DEVSEL_WAIT - 3'h1);
	wire m_end = m_xfer | ((m_st_q == M_DATA) & ~bus.stop_n) | m_tmo;
	wire start = (m_st_q == M_IDLE) & h_req_i & bus.frame_n & bus.irdy_n
		& (t_st_q == T_IDLE);
	wire adph = ~bus.frame_n & frame_prev_q & (m_st_q != M_ADDR);
	wire mem_cmd = (bus.cbe_n[3:0] == `PCIB_CMD_MEM_RD) |
		(bus.cbe_n[3:0] == `PCIB_CMD_MEM_WR);
	wire t_hit = adph & mem_cmd & (bus.ad[63:20] == HOST_BASE[63:20]);
	wire t_xfer = (t_st_q == T_DATA) & both_rdy;
	wire t_end = (t_st_q == T_DATA) & bus.frame_n & (t_xfer | bus.irdy_n);
	wire t_stop_d = t_stop_q | (t_xfer & h_tgt_disc_i);
	wire in_data = (t_st_q == T_DATA) & ~t_end;
	// ==========================================================
	// Next states
	always_comb begin
		m_st_d = m_st_q;
		case (m_st_q)
			M_IDLE: m_st_d = start ? M_ADDR : M_IDLE;
			M_ADDR: m_st_d = M_DATA;
			M_DATA: m_st_d = m_end ? M_END : M_DATA;
			M_END: m_st_d = M_IDLE;
			default: m_st_d = M_IDLE;
		endcase
	end
	always_comb begin
		t_st_d = t_st_q;
		case (t_st_q)
			T_IDLE: t_st_d = t_hit ? T_DATA : T_IDLE;
			T_DATA: t_st_d = t_end ? T_END : T_DATA;
			T_END: t_st_d = T_IDLE;
			default: t_st_d = T_IDLE;
		endcase
	end
	// ==========================================================
	// Drive assembly: single data phase, so frame lasts one clock
	wire m_own = (m_st_d == M_ADDR) | (m_st_d == M_DATA);
	wire m_ad_w = (m_st_d == M_ADDR) | ((m_st_d == M_DATA) & wr_q);
	wire t_ad_w = in_data & ~t_wr_q;
	assign v_d.ad = start ? h_addr_i : (t_ad_w ? h_tgt_rdata_i : ad_q);
	assign v_d.cbe_n = start ? {h_cmd_i, h_cmd_i} : ~be_q;
	assign v_d.par = 1'b0;
	assign v_d.par64 = 1'b0;
	assign v_d.frame_n = ~(m_st_d == M_ADDR);
	assign v_d.irdy_n = ~(m_st_d == M_DATA);
	assign v_d.trdy_n = ~(in_data & ~t_stop_d);
	assign v_d.stop_n = ~(in_data & (t_stop_d | h_tgt_disc_i));
	assign v_d.devsel_n = ~((t_st_d == T_DATA) & ~t_end);
	assign w_d = '{ad_lo: m_ad_w | t_ad_w, ad_hi: 1'b0, cbe_lo: m_own,
		cbe_hi: 1'b0, par: 1'b0, par64: 1'b0,
		frame: ~v_d.frame_n, irdy: ~v_d.irdy_n, trdy: ~v_d.trdy_n,
		stop: ~v_d.stop_n, devsel: ~v_d.devsel_n};
	assign bus_if.host_drv = drv_q;
	assign bus_if.host_oe = oe_q;
	assign bus_if.idsel = idsel_q;
	assign bus_if.wide = wide_q;
	// ==========================================================
	// Flops
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			drv_q <= '1;
			oe_q <= '0;
			m_st_q <= M_IDLE;
			t_st_q <= T_IDLE;
			t_stop_q <= 1'b0;
			frame_prev_q <= 1'b1;
			tmo_q <= 3'h0;
			idsel_q <= 1'b0;
			wide_q <= 1'b0;
		end else begin
			drv_q <= pcib_drv_next(v_d, bus);
			oe_q <= pcib_oe_next(w_d, oe_q, drv_q, wide_q);
			m_st_q <= m_st_d;
			t_st_q <= t_st_d;
			t_stop_q <= t_hit ? 1'b0 : t_stop_d;
			frame_prev_q <= bus.frame_n;
			tmo_q <= (m_st_q == M_DATA) ? tmo_q + 3'h1 : 3'h0;
			idsel_q <= h_idsel_i;
			wide_q <= h_wide_i;
		end
	end
	// Captured fields; data replaces the address after the address phase
	always_ff @(posedge ref_clk_i) begin
		if (start) begin
			wr_q <= h_cmd_i[0];
			cmd_q <= h_cmd_i;
			be_q <= h_be_i;
			ad_q <= h_wdata_i;
		end
		if (t_hit) begin
			t_wr_q <= bus.cbe_n[0];
		end
	end
	// User answers
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			h_busy_o <= 1'b0;
			h_rdata_o <= 64'h0;
			h_done_o <= 1'b0;
			h_abort_o <= 1'b0;
			h_tgt_wr_o <= 1'b0;
			h_tgt_wdata_o <= 64'h0;
			h_tgt_be_o <= 8'h0;
		end else begin
			h_busy_o <= (m_st_d != M_IDLE);
			if (m_xfer & ~wr_q) begin
				h_rdata_o <= wide_q ? bus.ad : {32'h0, bus.ad[31:0]};
			end
			h_done_o <= m_end;
			h_abort_o <= m_tmo & ~m_xfer;
			h_tgt_wr_o <= t_xfer & t_wr_q;
			if (t_xfer) begin
				h_tgt_wdata_o <= bus.ad;
				h_tgt_be_o <= ~bus.cbe_n;
			end
		end
	end
endmodule : pcib_host

// >>> test/pcib_assertions.sv
// Checker of the resolved bus lines between the two ends.
// Assumes one bus clock and instantiation beside the carrier.
`timescale 1ns/1ps
module pcib_assertions import pcib_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Carrier lines
	input wire pcib_drv_t bus,
	input wire pcib_oe_t dev_oe,
	input wire pcib_oe_t host_oe,
	input wire logic wide
);
	// ==========================================================
	// Phases
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// Address phase: first clock with frame low
	sequence s_addr;
		$fell(bus.frame_n);
	endsequence
	// Nobody claims for five data-phase clocks
	sequence s_unclaimed;
		s_addr ##1 bus.devsel_n [*5];
	endsequence
	// ==========================================================
	// Properties
	property p_par_lo;
		(dev_oe.par | host_oe.par) |->
			bus.par == ^{$past(bus.ad[31:0]), $past(bus.cbe_n[3:0])};
	endproperty
	a_par_lo:
		assert property (p_par_lo) else $error("low parity");
	property p_par_hi;
		(dev_oe.par64 | host_oe.par64) |->
			bus.par64 == ^{$past(bus.ad[63:32]), $past(bus.cbe_n[7:4])};
	endproperty
	a_par_hi:
		assert property (p_par_hi) else $error("high parity");
	property p_narrow;
		!wide |-> !(dev_oe.ad_hi | dev_oe.cbe_hi | dev_oe.par64 |
			host_oe.ad_hi | host_oe.cbe_hi | host_oe.par64);
	endproperty
	a_narrow:
		assert property (p_narrow) else $error("upper lanes driven");
	// Reset itself is the cause here, so it cannot disable the check
	property p_reset;
		disable iff (1'b0) reset_i |=>
			dev_oe == '0 && host_oe == '0;
	endproperty
	a_reset:
		assert property (p_reset) else $error("driven in reset");
	property p_release;
		($fell(dev_oe.frame) || $fell(host_oe.frame)) |->
			$past(bus.frame_n);
	endproperty
	a_release:
		assert property (p_release) else $error("frame left low");
	property p_addr;
		s_addr |-> (dev_oe.ad_lo && dev_oe.cbe_lo) ||
			(host_oe.ad_lo && host_oe.cbe_lo);
	endproperty
	a_addr:
		assert property (p_addr) else $error("empty address phase");
	property p_last;
		$rose(bus.frame_n) |-> !bus.irdy_n;
	endproperty
	a_last:
		assert property (p_last) else $error("frame off too early");
	property p_abort;
		s_unclaimed |-> ##[1:3] (bus.frame_n && bus.irdy_n);
	endproperty
	a_abort:
		assert property (p_abort) else $error("no master abort");
endmodule : pcib_assertions

// >>> test/tb.sv
// Bench joining both bus ends through the carrier, random traffic.
// Assumes package, carrier and both ends compiled first.
`timescale 1ns/1ps
`include "pcib_defines.svh"
module tb;
	import pcib_pkg::*;
	// ==========================================================
	// Signals
	logic ref_clk_i = 0, reset_i = 1, mst_req_i = 0, tgt_busy_i = 0;
	logic h_idsel_i = 1, h_wide_i = 1, h_req_i = 0, h_tgt_disc_i = 0;
	logic [3:0] mst_cmd_i = 0, mst_len_i = 4'h2, h_cmd_i = 0;
	logic [7:0] mst_be_i = 8'hff, h_be_i = 8'hff, tgt_be_o, h_tgt_be_o;
	logic [63:0] mst_addr_i = 0, mst_wdata_i = 0, h_addr_i = 0;
	logic [63:0] h_wdata_i = 0, h_tgt_rdata_i = 0, mst_rdata_o;
	logic [63:0] tgt_addr_o, tgt_wdata_o, h_rdata_o, h_tgt_wdata_o;
	logic mst_busy_o, mst_rvalid_o, mst_done_o, mst_abort_o, tgt_rd_o;
	logic mst_stopped_o, tgt_wr_o, h_busy_o, h_done_o, h_abort_o;
	logic h_tgt_wr_o, ab, st;
	logic [7:0] tbe, eb;
	logic [63:0] tw, ta, hr, d, a, rd[4];
	logic [31:0] sd = 32'he45f;
	logic [3:0] wc[3] = '{`PCIB_CMD_MEM_WR, `PCIB_CMD_IO_WR,
		`PCIB_CMD_CFG_WR};
	logic [63:0] ba[3] = '{`PCIB_DEV_MEM_BASE,
		{32'h0, `PCIB_DEV_IO_BASE} + 64'h1, 64'h0};
	int n_errors = 0, checks_done = 0, nr;
	pcib_if bus_if();
	pcib_dev u_pcib_dev(.ref_clk_i, .reset_i, .bus_if, .mst_req_i,
		.mst_cmd_i, .mst_addr_i, .mst_len_i, .mst_wdata_i, .mst_be_i,
		.mst_busy_o, .mst_rdata_o, .mst_rvalid_o, .mst_done_o,
		.mst_abort_o, .mst_stopped_o, .tgt_busy_i, .tgt_wr_o, .tgt_rd_o,
		.tgt_addr_o, .tgt_wdata_o, .tgt_be_o);
	pcib_host u_pcib_host(.ref_clk_i, .reset_i, .bus_if, .h_idsel_i,
		.h_wide_i, .h_req_i, .h_cmd_i, .h_addr_i, .h_wdata_i, .h_be_i,
		.h_busy_o, .h_rdata_o, .h_done_o, .h_abort_o, .h_tgt_rdata_i,
		.h_tgt_disc_i, .h_tgt_wr_o, .h_tgt_wdata_o, .h_tgt_be_o);
	pcib_assertions u_chk(.ref_clk_i, .reset_i, .bus(bus_if.bus),
		.dev_oe(bus_if.dev_oe), .host_oe(bus_if.host_oe),
		.wide(bus_if.wide));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] lf(logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
	endfunction : lf
	// Lane mask: enable bit n covers byte lane n
	function automatic logic [63:0] mk(logic [7:0] b);
		for (int i = 0; i < 8; i++) mk[8*i +: 8] = {8{b[i]}};
	endfunction : mk
	// Upper lanes read as zero on a narrow bus
	function automatic logic [63:0] nar(logic [63:0] v, logic w);
		return w ? v : {32'h0, v[31:0]};
	endfunction : nar
	task automatic rn();
		sd = lf(sd);
		d = {sd, lf(sd)};
	endtask : rn
	task automatic chk(input logic [63:0] g, e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic final_report();
		if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	// One transfer from either end; level request dropped once taken
	task automatic op(input bit m, input logic [3:0] c,
		input logic [63:0] ad);
		bit fin;
		@(negedge ref_clk_i);
		{mst_cmd_i, mst_addr_i, mst_wdata_i, mst_req_i} = {c, ad, d, m};
		{h_cmd_i, h_addr_i, h_wdata_i, h_req_i} = {c, ad, d, !m};
		{ab, st, nr, tw, ta, fin} = '0;
		repeat (80) begin
			@(negedge ref_clk_i);
			sd = lf(sd);
			tgt_busy_i = sd[3]; // Random target wait states
			if (mst_busy_o) mst_req_i = 0;
			if (h_busy_o) h_req_i = 0;
			if (tgt_wr_o) {tw, tbe} = {tgt_wdata_o, tgt_be_o};
			if (tgt_wr_o | tgt_rd_o) ta = tgt_addr_o;
			if (h_tgt_wr_o) tw = h_tgt_wdata_o;
			if (mst_rvalid_o && nr < 4) rd[nr++] = mst_rdata_o;
			if (h_done_o) hr = h_rdata_o;
			ab |= mst_abort_o | h_abort_o;
			st |= mst_stopped_o;
			fin = m ? mst_done_o : (h_done_o | h_abort_o);
			if (fin) break;
		end
		// A transfer that never ends counts against the run
		if (!fin) n_errors++;
	endtask : op
	// ==========================================================
	// Sequence
	initial forever #4 ref_clk_i = ~ref_clk_i;
	initial begin
		repeat (4000) @(posedge ref_clk_i);
		n_errors++;
		final_report();
	end
	initial begin
		repeat (10) @(negedge ref_clk_i);
		reset_i = 0;
		// Every space and word, wide then narrow, write then read back
		for (int i = 0; i < 8; i++) begin
			h_wide_i = !i[2];
			for (int j = 0; j < 3; j++) begin
				rn();
				h_be_i = sd[7:0];
				eb = h_be_i & {{4{h_wide_i}}, 4'hf};
				a = ba[j] + {59'h0, i[1:0], 3'h0};
				op(0, wc[j], a);
				chk(tw, nar(d, h_wide_i));
				chk({56'h0, tbe}, {56'h0, eb});
				chk(ta, a);
				h_be_i = 8'hff;
				op(0, wc[j] ^ 4'h1, a);
				chk(hr & mk(eb), nar(d, h_wide_i) & mk(eb));
				chk(ta, a);
			end
		end
		h_idsel_i = 0;
		op(0, `PCIB_CMD_CFG_WR, 64'h0);
		chk({63'h0, ab}, 64'h1);
		{h_idsel_i, h_wide_i} = 2'h3;
		rn();
		h_tgt_rdata_i = d;
		op(1, `PCIB_CMD_MEM_RD, `PCIB_HOST_MEM_BASE);
		chk(64'(nr), 64'h2);
		chk(rd[1], d);
		op(1, `PCIB_CMD_MEM_WR, `PCIB_HOST_MEM_BASE);
		chk(tw, d);
		chk({56'h0, h_tgt_be_o}, {56'h0, mst_be_i});
		op(1, `PCIB_CMD_MEM_RD, 64'h0);
		chk({63'h0, ab}, 64'h1);
		{h_tgt_disc_i, mst_len_i} = {1'b1, 4'h3};
		op(1, `PCIB_CMD_MEM_RD, `PCIB_HOST_MEM_BASE);
		chk({63'h0, st}, 64'h1);
		final_report();
	end
endmodule : tb
